// >>> logic/frequency_counter.sv
// Function
// - In IF mode the selected IF pin's edges are counted over a 1, 4 or 8 ms or open gate.
// - In external gate mode a 1, 100 or 900 kHz reference is counted between gate rises.
// - Both functions accumulate in one 16-bit binary counter.
// - The mode select register makes the IF pins port inputs or IF count inputs.
// - The gate pin is a general-purpose I/O pin or the external gate input.
// - In IF mode an interrupt request is raised when the internal gate closes.
// - Counting is governed through registers 23H, 04H and 3AH.
// - The count is read at peripheral address 43H through the transfer buffer.
// - Function select 00 clock port, 01 FM IF, 10 AM IF, 11 external gate.
// - Gate time select 00 1ms/1kHz, 01 4ms/100kHz, 10 8ms/900kHz, 11 open/0kHz.
// - Counting begins when software sets the start flag in IF mode, at the first gate rise after it in external gate mode.
`timescale 1ns/1ns
`include "frequency_counter_cfg.svh"

module frequency_counter
    import frequency_counter_pkg::*;
#(
    parameter int unsigned GATE_1MS_CYC = `FC_US_TO_CYC(`FC_GATE_1MS_US),
    parameter int unsigned GATE_4MS_CYC = `FC_US_TO_CYC(`FC_GATE_4MS_US),
    parameter int unsigned GATE_8MS_CYC = `FC_US_TO_CYC(`FC_GATE_8MS_US),
    parameter int unsigned REF_1KHZ_CYC = `FC_HZ_TO_CYC(`FC_REF_1KHZ_HZ),
    parameter int unsigned REF_100KHZ_CYC = `FC_HZ_TO_CYC(`FC_REF_100KHZ_HZ),
    parameter int unsigned REF_900KHZ_CYC = `FC_HZ_TO_CYC(`FC_REF_900KHZ_HZ)
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic [6:0] RF_ADDR,
    input wire logic [3:0] RF_WDATA,
    input wire logic RF_WE,
    input wire logic RF_RE,
    output logic [3:0] RF_RDATA,
    input wire logic [6:0] PERI_ADDR,
    input wire logic PERI_RD,
    output logic [15:0] TRANSFER_BUFFER,
    input wire logic FM_IF_INPUT,
    input wire logic AM_IF_INPUT,
    output logic FM_PORT_IN,
    output logic AM_PORT_IN,
    input wire logic EXT_GATE_PIN_I,
    output logic EXT_GATE_PIN_O,
    output logic EXT_GATE_PIN_OE_N,
    output logic GATE_PORT_IN,
    input wire logic GATE_PIN_DIRECTION,
    input wire logic GATE_PORT_LATCH,
    output logic IRQ_REQUEST
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Gate length in cycles, less one since the timer counts to zero
    function automatic logic [16:0] gate_cycles(input logic [1:0] sel);
        logic [16:0] c;
        c = 17'h00000;
        if (sel == 2'b00) begin
            c = 17'(GATE_1MS_CYC - 1);
        end else if (sel == 2'b01) begin
            c = 17'(GATE_4MS_CYC - 1);
        end else if (sel == 2'b10) begin
            c = 17'(GATE_8MS_CYC - 1);
        end
        return c;
    endfunction

    // Reference period in cycles, less one
    function automatic logic [13:0] ref_cycles(input logic [1:0] sel);
        logic [13:0] c;
        c = 14'h0000;
        if (sel == 2'b00) begin
            c = 14'(REF_1KHZ_CYC - 1);
        end else if (sel == 2'b01) begin
            c = 14'(REF_100KHZ_CYC - 1);
        end else if (sel == 2'b10) begin
            c = 14'(REF_900KHZ_CYC - 1);
        end
        return c;
    endfunction

    fc_state_t s;
    fc_state_t next_s;

    logic is_if;
    logic is_ext;
    logic if_in;
    logic if_rise;
    logic gate_in;
    logic gate_rise;
    logic ref_tick;
    logic open_gate;

    // ------------------------------------------------------------
    // Input selection and edge detection
    // ------------------------------------------------------------
    // Inputs are synchronous, so one previous-value flop finds edges
    assign is_if = (s.mode.func_sel == FUNC_FM_IF) || (s.mode.func_sel == FUNC_AM_IF);
    assign is_ext = (s.mode.func_sel == FUNC_EXT_GATE) && !GATE_PIN_DIRECTION;
    assign if_in = (s.mode.func_sel == FUNC_FM_IF) ? FM_IF_INPUT : AM_IF_INPUT;
    assign if_rise = is_if && if_in && !s.if_prev;
    assign gate_in = EXT_GATE_PIN_I;
    assign gate_rise = is_ext && gate_in && !s.gate_prev;
    assign ref_tick = (s.ref_div == 14'h0000) && (s.mode.gate_time_sel != 2'b11);
    assign open_gate = (s.mode.gate_time_sel == 2'b11);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.if_prev = if_in;
        next_s.gate_prev = gate_in;
        // Reference divider free-runs; restarts on each start
        if (s.ref_div == 14'h0000) begin
            next_s.ref_div = ref_cycles(s.mode.gate_time_sel);
        end else begin
            next_s.ref_div = s.ref_div - 14'h0001;
        end

        // Counting sequence
        case (s.phase)
            PH_IDLE: begin
                next_s.gate_open = 1'b0;
            end
            PH_ARMED: begin
                // Count window starts on the first gate rise
                if (gate_rise) begin
                    next_s.phase = PH_OPEN;
                    next_s.gate_open = 1'b1;
                    next_s.count = 16'h0000;
                    next_s.ref_div = ref_cycles(s.mode.gate_time_sel);
                end
            end
            PH_OPEN: begin
                if (is_if) begin
                    if (if_rise) begin
                        next_s.count = s.count + 16'h0001;
                    end
                    // Open gate never times out; software stops it
                    if (!open_gate) begin
                        if (s.timer == 17'h00000) begin
                            next_s.phase = PH_IDLE;
                            next_s.gate_open = 1'b0;
                        end else begin
                            next_s.timer = s.timer - 17'h00001;
                        end
                    end
                end else begin
                    if (ref_tick) begin
                        next_s.count = s.count + 16'h0001;
                    end
                    // Second rise closes the window
                    if (gate_rise) begin
                        next_s.phase = PH_IDLE;
                        next_s.gate_open = 1'b0;
                    end
                end
            end
            default: begin
                next_s.phase = PH_IDLE;
            end
        endcase

        // Register writes
        if (RF_WE) begin
            if (RF_ADDR == `FC_ADDR_MODE_SELECT) begin
                next_s.mode = mode_t'(RF_WDATA);
            end else if (RF_ADDR == `FC_ADDR_COUNTER_CONTROL) begin
                // Clock generator function owns the shared counter, so start is ignored
                if (RF_WDATA[`FC_BIT_START] && s.mode.func_sel != FUNC_CLOCK_GEN) begin
                    next_s.count = 16'h0000;
                    next_s.timer = gate_cycles(s.mode.gate_time_sel);
                    next_s.ref_div = ref_cycles(s.mode.gate_time_sel);
                    next_s.phase = is_if ? PH_OPEN : PH_ARMED;
                    next_s.gate_open = is_if;
                end else if (!RF_WDATA[`FC_BIT_START]) begin
                    next_s.phase = PH_IDLE;
                    next_s.gate_open = 1'b0;
                end
            end else if (RF_ADDR == `FC_ADDR_IRQ_REQUEST) begin
                next_s.irq = RF_WDATA[`FC_BIT_IRQ];
            end
        end

        // Gate close in IF mode requests an interrupt; set wins over a clear
        if (s.phase == PH_OPEN && is_if && !open_gate && s.timer == 17'h00000) begin
            next_s.irq = 1'b1;
        end

        // Register reads, answered one cycle later
        if (RF_RE) begin
            if (RF_ADDR == `FC_ADDR_GATE_OPEN_STATUS) begin
                next_s.rdata = {3'h0, s.gate_open};
            end else if (RF_ADDR == `FC_ADDR_MODE_SELECT) begin
                next_s.rdata = s.mode;
            end else if (RF_ADDR == `FC_ADDR_COUNTER_CONTROL) begin
                next_s.rdata = {3'h0, s.phase != PH_IDLE};
            end else if (RF_ADDR == `FC_ADDR_IRQ_REQUEST) begin
                next_s.rdata = {3'h0, s.irq};
            end else begin
                next_s.rdata = 4'h0;
            end
        end
        if (PERI_RD && PERI_ADDR == `FC_ADDR_COUNT_RESULT) begin
            next_s.transfer_buffer = s.count;
        end

        // Port functions of the shared pins
        next_s.fm_port_in = (s.mode.func_sel == FUNC_FM_IF) ? 1'b0 : FM_IF_INPUT;
        next_s.am_port_in = (s.mode.func_sel == FUNC_AM_IF) ? 1'b0 : AM_IF_INPUT;
        next_s.gate.port_in = gate_in;
        next_s.gate.o = GATE_PORT_LATCH;
        next_s.gate.oe_n = !GATE_PIN_DIRECTION;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            s <= '0;
            s.mode <= mode_t'(`FC_MODE_RESET);
            s.gate.oe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state flops
    assign RF_RDATA = s.rdata;
    assign TRANSFER_BUFFER = s.transfer_buffer;
    assign FM_PORT_IN = s.fm_port_in;
    assign AM_PORT_IN = s.am_port_in;
    assign EXT_GATE_PIN_O = s.gate.o;
    assign EXT_GATE_PIN_OE_N = s.gate.oe_n;
    assign GATE_PORT_IN = s.gate.port_in;
    assign IRQ_REQUEST = s.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    sequence start_wr;
        RF_WE && RF_ADDR == `FC_ADDR_COUNTER_CONTROL && RF_WDATA[`FC_BIT_START];
    endsequence
    sequence gate_timeout;
        s.phase == PH_OPEN && is_if && !open_gate && s.timer == 17'h00000;
    endsequence

    a_if_edge_count: assert property (s.phase == PH_OPEN && if_rise && !RF_WE
        |=> s.count == $past(s.count) + 16'h0001)
        else $error("IF edge not counted");
    a_ext_ref_count: assert property (s.phase == PH_OPEN && is_ext && ref_tick && !RF_WE
        |=> s.count == $past(s.count) + 16'h0001)
        else $error("reference tick not counted");
    a_count_hold_idle: assert property (s.phase == PH_IDLE && !RF_WE
        |=> $stable(s.count))
        else $error("count moved while idle");
    a_irq_on_close: assert property (gate_timeout |=> IRQ_REQUEST && !s.gate_open)
        else $error("gate close gave no interrupt");
    a_irq_cause: assert property ($rose(IRQ_REQUEST) |-> $past(s.phase == PH_OPEN && is_if
        && !open_gate && s.timer == 17'h00000)
        || $past(RF_WE && RF_ADDR == `FC_ADDR_IRQ_REQUEST))
        else $error("interrupt without cause");
    a_start_opens: assert property (start_wr ##0 is_if |=> s.gate_open)
        else $error("start did not open gate");
    a_gate_status_read: assert property (RF_RE && RF_ADDR == `FC_ADDR_GATE_OPEN_STATUS
        |=> RF_RDATA[`FC_BIT_GATE_OPEN] == $past(s.gate_open))
        else $error("gate status read wrong");
    a_result_read: assert property (PERI_RD && PERI_ADDR == `FC_ADDR_COUNT_RESULT
        |=> TRANSFER_BUFFER == $past(s.count))
        else $error("count transfer wrong");
    a_clkgen_no_run: assert property (s.mode.func_sel == FUNC_CLOCK_GEN && s.phase == PH_IDLE
        && !(RF_WE && RF_ADDR == `FC_ADDR_MODE_SELECT) |=> s.phase == PH_IDLE)
        else $error("counter ran in clock port mode");
    a_gate_pin_drive: assert property (GATE_PIN_DIRECTION |=> !EXT_GATE_PIN_OE_N)
        else $error("gate pin not driven as output");

endmodule

// >>> include/frequency_counter_cfg.svh
`ifndef FREQUENCY_COUNTER_CFG_SVH
`define FREQUENCY_COUNTER_CFG_SVH

// ----------------------------------------------------------------
// Register file addresses (4-bit data registers)
// ----------------------------------------------------------------
`define FC_ADDR_GATE_OPEN_STATUS 7'h04
`define FC_ADDR_MODE_SELECT 7'h12
`define FC_ADDR_COUNTER_CONTROL 7'h23
`define FC_ADDR_IRQ_REQUEST 7'h3a
// Peripheral address of the 16-bit count, read via the transfer buffer
`define FC_ADDR_COUNT_RESULT 7'h43

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define FC_BIT_START 0
`define FC_BIT_GATE_OPEN 0
`define FC_BIT_IRQ 0
`define FC_MODE_RESET 4'h0

// ----------------------------------------------------------------
// Timing (clock period, gate times, reference rates)
// ----------------------------------------------------------------
`define FC_CLK_NS 100
`define FC_GATE_1MS_US 1000
`define FC_GATE_4MS_US 4000
`define FC_GATE_8MS_US 8000
`define FC_REF_1KHZ_HZ 1000
`define FC_REF_100KHZ_HZ 100000
`define FC_REF_900KHZ_HZ 900000
// Gate times round down, reference periods round down
`define FC_US_TO_CYC(us) (((us) * 1000) / `FC_CLK_NS)
`define FC_HZ_TO_CYC(hz) (1000000000 / ((hz) * `FC_CLK_NS))

`endif

// >>> include/frequency_counter_pkg.sv
package frequency_counter_pkg;

    // Function select encoding
    typedef enum logic [1:0] {
        FUNC_CLOCK_GEN = 2'b00,
        FUNC_FM_IF = 2'b01,
        FUNC_AM_IF = 2'b10,
        FUNC_EXT_GATE = 2'b11
    } func_t;

    // Counting phase
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_ARMED = 2'b01,
        PH_OPEN = 2'b10
    } phase_t;

    // Mode select register: function select high/low, gate time select high/low
    typedef struct packed {
        func_t func_sel;
        logic [1:0] gate_time_sel;
    } mode_t;

    // Gate pin drive
    typedef struct packed {
        logic o;
        logic oe_n;
        logic port_in;
    } gate_pin_t;

    // Whole block state
    typedef struct packed {
        mode_t mode;
        phase_t phase;
        logic gate_open;
        logic irq;
        logic [15:0] count;
        logic [16:0] timer;
        logic [13:0] ref_div;
        logic if_prev;
        logic gate_prev;
        logic [3:0] rdata;
        logic [15:0] transfer_buffer;
        logic fm_port_in;
        logic am_port_in;
        gate_pin_t gate;
    } fc_state_t;

endpackage

// >>> verification/freq_source.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Tuner IF signals and external gate pulse source
// ----------------------------------------------------------------
module freq_source #(
    parameter int GATE_PER = 500
) (
    input wire logic clk,
    input wire logic gate_on,
    output logic fm,
    output logic am,
    output logic gate
);
    int cnt = 0;
    // Start low so the first edges are clean rises, not unknowns
    initial begin
        {fm, am, gate} = 3'b000;
    end
    // FM rises every 2 cycles, AM every 4; gate is a 20-cycle pulse per period
    always @(posedge clk) begin
        cnt <= cnt + 1;
        fm <= ~fm;
        am <= cnt[0] ? ~am : am;
        gate <= gate_on && ((cnt % GATE_PER) < 20);
    end
endmodule

// >>> verification/frequency_counter_tb.sv
`timescale 1ns/1ns
`include "frequency_counter_cfg.svh"
module frequency_counter_tb;
    import frequency_counter_pkg::*;
    localparam int GPER = 500;
    logic clk = 1'b0, rstn = 1'b0, rf_we = 1'b0, rf_re = 1'b0, peri_rd = 1'b0;
    logic [6:0] rf_addr = 7'h00, peri_addr = 7'h00;
    logic [3:0] rf_wdata = 4'h0, rf_rdata;
    logic [15:0] tbuf;
    logic fm, am, gate, gate_on = 1'b0, ext_i, ext_o, ext_oe_n, gate_port_in;
    logic fm_port_in, am_port_in, gate_dir = 1'b0, gate_latch = 1'b0, irq;
    int n_errors = 0, n_checks = 0;
    // ------------------------------------------------------------
    // Clock, pin resolution, design and partner
    // ------------------------------------------------------------
    initial begin
        forever #50 clk = ~clk;
    end
    // Gate wire follows the device when it drives, else the pulse source
    assign ext_i = ext_oe_n ? gate : ext_o;
    frequency_counter #(.GATE_1MS_CYC(20), .GATE_4MS_CYC(40), .GATE_8MS_CYC(80),
        .REF_1KHZ_CYC(50)) dut (.CLK(clk), .RSTN(rstn), .RF_ADDR(rf_addr),
        .RF_WDATA(rf_wdata), .RF_WE(rf_we), .RF_RE(rf_re), .RF_RDATA(rf_rdata),
        .PERI_ADDR(peri_addr), .PERI_RD(peri_rd), .TRANSFER_BUFFER(tbuf),
        .FM_IF_INPUT(fm), .AM_IF_INPUT(am), .FM_PORT_IN(fm_port_in),
        .AM_PORT_IN(am_port_in), .EXT_GATE_PIN_I(ext_i), .EXT_GATE_PIN_O(ext_o),
        .EXT_GATE_PIN_OE_N(ext_oe_n), .GATE_PORT_IN(gate_port_in),
        .GATE_PIN_DIRECTION(gate_dir), .GATE_PORT_LATCH(gate_latch), .IRQ_REQUEST(irq));
    freq_source #(.GATE_PER(GPER)) src (.clk(clk), .gate_on(gate_on), .fm(fm), .am(am),
        .gate(gate));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Strobes drop one cycle before the next request may raise them again
    task automatic rf_write(input logic [6:0] a, input logic [3:0] d);
        rf_addr = a;
        rf_wdata = d;
        rf_we = 1'b1;
        @(posedge clk);
        #10;
        rf_we = 1'b0;
        @(posedge clk);
        #10;
    endtask
    task automatic rf_read(input logic [6:0] a, output logic [3:0] d);
        rf_addr = a;
        rf_re = 1'b1;
        @(posedge clk);
        #10;
        rf_re = 1'b0;
        @(posedge clk);
        #10;
        d = rf_rdata;
    endtask
    task automatic count_near(input int lo, input int hi);
        peri_addr = `FC_ADDR_COUNT_RESULT;
        peri_rd = 1'b1;
        @(posedge clk);
        #10;
        peri_rd = 1'b0;
        @(posedge clk);
        #10;
        check(16'(tbuf >= 16'(lo) && tbuf <= 16'(hi)), 16'h1);
    endtask
    task automatic final_report();
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [6:0] a [5] = '{`FC_ADDR_GATE_OPEN_STATUS, `FC_ADDR_MODE_SELECT,
            `FC_ADDR_COUNTER_CONTROL, `FC_ADDR_IRQ_REQUEST, 7'h55};
        logic [3:0] d;
        foreach (a[i]) begin
            rf_read(a[i], d);
            check(16'(d), 16'h0);
        end
    endtask
    // IF count over an internal gate; per is the source's rise spacing
    task automatic t_if(input func_t f, input logic [1:0] s, input int g, input int per);
        logic [3:0] d;
        int n;
        n = 0;
        rf_write(`FC_ADDR_MODE_SELECT, {f, s});
        rf_write(`FC_ADDR_COUNTER_CONTROL, 4'h1);
        while (irq !== 1'b1 && n < 1000) begin
            @(posedge clk);
            #10;
            n++;
        end
        // The write task spends one edge after the start edge, so add it back
        check(16'(n + 1), 16'(g));
        check(16'(f == FUNC_FM_IF ? fm_port_in : am_port_in), 16'h0);
        rf_read(`FC_ADDR_GATE_OPEN_STATUS, d);
        check(16'(d), 16'h0);
        count_near(g / per - 1, g / per + 1);
        rf_write(`FC_ADDR_IRQ_REQUEST, 4'h0);
        rf_read(`FC_ADDR_IRQ_REQUEST, d);
        check({11'h0, d, irq}, 16'h0);
    endtask
    // Open gate runs until stopped and never interrupts
    task automatic t_open();
        logic [3:0] d;
        rf_write(`FC_ADDR_MODE_SELECT, {FUNC_FM_IF, 2'b11});
        rf_write(`FC_ADDR_COUNTER_CONTROL, 4'h1);
        repeat (60) @(posedge clk);
        #10;
        rf_read(`FC_ADDR_GATE_OPEN_STATUS, d);
        check(16'(d), 16'h1);
        rf_write(`FC_ADDR_COUNTER_CONTROL, 4'h0);
        rf_read(`FC_ADDR_COUNTER_CONTROL, d);
        check({11'h0, d, irq}, 16'h0);
        // 64 counting edges from start to stop, one FM rise per two
        count_near(31, 33);
    endtask
    // Reference ticks counted between two gate rises
    task automatic t_ext(input logic [1:0] s, input int expn, input int tol);
        logic [3:0] d;
        int n;
        n = 0;
        gate_dir = 1'b0;
        gate_on = 1'b1;
        rf_write(`FC_ADDR_MODE_SELECT, {FUNC_EXT_GATE, s});
        rf_write(`FC_ADDR_COUNTER_CONTROL, 4'h1);
        d = 4'h0;
        while (d !== 4'h1 && n < 400) begin
            rf_read(`FC_ADDR_GATE_OPEN_STATUS, d);
            n++;
        end
        while (d !== 4'h0 && n < 800) begin
            rf_read(`FC_ADDR_GATE_OPEN_STATUS, d);
            n++;
        end
        check(16'(n < 800), 16'h1);
        check(16'(irq), 16'h0);
        count_near(expn - tol, expn + tol);
        gate_on = 1'b0;
    endtask
    // Clock generator function: start refused, pins act as ports
    task automatic t_port();
        logic [3:0] d;
        rf_write(`FC_ADDR_MODE_SELECT, {FUNC_CLOCK_GEN, 2'b00});
        rf_write(`FC_ADDR_COUNTER_CONTROL, 4'h1);
        rf_write(`FC_ADDR_GATE_OPEN_STATUS, 4'h1);
        rf_read(`FC_ADDR_COUNTER_CONTROL, d);
        check(16'(d), 16'h0);
        rf_read(`FC_ADDR_GATE_OPEN_STATUS, d);
        check(16'(d), 16'h0);
        // Port copy lags the pin by one edge, the source toggles every edge
        check(16'(fm_port_in), {15'h0, ~fm});
        gate_dir = 1'b1;
        gate_latch = 1'b1;
        @(posedge clk);
        #10;
        check({14'h0, ext_oe_n, ext_o}, 16'h1);
        gate_dir = 1'b0;
        @(posedge clk);
        #10;
        check(16'(ext_oe_n), 16'h1);
        // Pin read back while it was still driven high
        check(16'(gate_port_in), 16'h1);
    endtask
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        #10;
        check(16'(ext_oe_n), 16'h1);
        rstn = 1'b1;
        t_reset();
        t_if(FUNC_FM_IF, 2'b00, 20, 2);
        t_if(FUNC_FM_IF, 2'b01, 40, 2);
        t_if(FUNC_FM_IF, 2'b10, 80, 2);
        t_if(FUNC_AM_IF, 2'b10, 80, 4);
        t_open();
        t_ext(2'b00, GPER / 50, 1);
        t_ext(2'b01, GPER / 100, 1);
        t_ext(2'b10, GPER / 11, 1);
        // Zero reference rate: the window opens and closes but nothing is counted
        t_ext(2'b11, 0, 0);
        t_port();
        final_report();
    end
    initial begin
        #2000000;
        n_errors++;
        final_report();
    end
endmodule
